// ==== core/flash_lock_and_reset_commands.sv ====
// global lock/unlock and software reset command decoder with AHB-Lite registers
//
// Functional notes
// - opcode 7Eh sets every block and sector lock bit to one.
// - opcode 98h clears every block and sector lock bit to zero.
// - accepted reset aborts work and clears all volatile settings.
// - reset happens only when 66h is directly followed by 99h.
// - any other command after 66h drops the reset-enabled state.
// - for about 30us after reset every command is ignored.
// - lock bits come up as one after power-up or reset.
// - lock bits decide protection only when scheme select is one.
`timescale 1ns/1ps
`include "flash_lock_consts.svh"
module flash_lock_and_reset_commands #(
    parameter int LOCK_AW    = 6,
    parameter int RST_CYCLES = (`RST_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input  wire logic                 hclk,           // system clock
    input  wire logic                 hresetn,        // async reset, active low
    input  wire logic                 hsel,           // slave select
    input  wire logic [31:0]          haddr,          // byte address
    input  wire logic [1:0]           htrans,         // transfer type
    input  wire logic                 hwrite,         // write when high
    input  wire logic [2:0]           hsize,          // transfer size
    input  wire flash_lock_pkg::word_t hwdata,        // write data
    input  wire logic                 hready,         // bus ready in
    output logic                      hreadyout,      // slave ready
    output flash_lock_pkg::word_t     hrdata,         // read data
    output logic                      hresp,          // always okay
    input  wire logic                 spi_cs_n,       // chip select, active low
    input  wire logic                 spi_clk,        // serial clock
    input  wire logic                 serial_data_in  // serial data
);
    import flash_lock_pkg::*;

    localparam int CW = $clog2(RST_CYCLES + 1);
    localparam int P_CS = 2;
    localparam int P_CK = 1;
    localparam int P_DI = 0;

    // pin synchronisers and filters
    logic [2:0]  pin_raw;
    logic [2:0]  s1_r;
    logic [2:0]  s2_r;
    logic [2:0]  s3_r;
    logic [2:0]  pin_f_r;
    logic [2:0]  pin_d_r;
    // frame shifter
    logic [3:0]  bit_cnt_r;
    opcode_t     shreg_r;
    opcode_t     last_op_r;
    logic        rst_en_r;
    logic        rst_en_nxt;
    dev_state_t  state_r;
    dev_state_t  state_nxt;
    logic [CW-1:0] rst_cnt_r;
    // registers
    logic [`CFG_W-1:0] cfg_r;
    logic [`VOL_W-1:0] vol_r;
    logic [LOCK_AW-1:0] qidx_r;
    logic        lock_bit;
    // bus phase
    logic        wr_pend_r;
    logic        rd_pend_r;
    logic [7:0]  addr_r;

    assign pin_raw = {spi_cs_n, spi_clk, serial_data_in};

    // three flops per pin, value taken once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pin
            localparam logic RV = (g == P_CS);
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1_r[g]    <= RV;
                    s2_r[g]    <= RV;
                    s3_r[g]    <= RV;
                    pin_f_r[g] <= RV;
                    pin_d_r[g] <= RV;
                end else begin
                    s1_r[g] <= pin_raw[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (s2_r[g] == s3_r[g]) begin
                        pin_f_r[g] <= s3_r[g];
                    end
                    pin_d_r[g] <= pin_f_r[g];
                end
            end
        end
    endgenerate

    // edges of the filtered pins
    wire cs_fall  = ~pin_f_r[P_CS] & pin_d_r[P_CS];
    wire cs_rise  = pin_f_r[P_CS] & ~pin_d_r[P_CS];
    wire clk_rise = pin_f_r[P_CK] & ~pin_d_r[P_CK] & ~pin_f_r[P_CS];

    // command decode at frame end; nothing taken while resetting
    wire dev_ready  = (state_r == DEV_READY);
    wire cmd_end    = cs_rise & (bit_cnt_r >= `OP_BITS) & dev_ready;
    wire cmd_lone   = cmd_end & (bit_cnt_r == `OP_BITS);
    wire do_lock    = cmd_lone & (shreg_r == `OP_GLOBAL_LOCK);
    wire do_unlock  = cmd_lone & (shreg_r == `OP_GLOBAL_UNLOCK);
    wire do_ren     = cmd_lone & (shreg_r == `OP_RESET_ENABLE);
    wire do_rst     = cmd_lone & (shreg_r == `OP_RESET_DEVICE) & rst_en_r;

    // serial shifter, opcode first, msb first, count saturates
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_cnt_r <= 4'h0;
            shreg_r   <= 8'h00;
        end else if (cs_fall) begin
            bit_cnt_r <= 4'h0;
        end else if (clk_rise && bit_cnt_r != `OP_BITS_SAT) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r < `OP_BITS) begin
                shreg_r <= {shreg_r[6:0], pin_f_r[P_DI]};
            end
        end
    end

    // reset-enabled latch
    always_comb begin
        rst_en_nxt = rst_en_r;
        if (do_rst) begin
            rst_en_nxt = 1'b0;
        end else if (do_ren) begin
            rst_en_nxt = 1'b1;
        end else if (cmd_end) begin
            rst_en_nxt = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_en_r  <= 1'b0;
            last_op_r <= 8'h00;
        end else begin
            rst_en_r <= rst_en_nxt;
            if (cmd_end) begin
                last_op_r <= shreg_r;
            end
        end
    end

    // reset recovery sequencer
    wire rst_done = (rst_cnt_r == '0);
    always_comb begin
        case (state_r)
            DEV_READY:     state_nxt = do_rst ? DEV_RESETTING : DEV_READY;
            DEV_RESETTING: state_nxt = rst_done ? DEV_READY : DEV_RESETTING;
            default:       state_nxt = DEV_READY;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r   <= DEV_READY;
            rst_cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (do_rst) begin
                rst_cnt_r <= CW'(RST_CYCLES - 1);
            end else if (!rst_done) begin
                rst_cnt_r <= rst_cnt_r - CW'(1);
            end
        end
    end

    // lock bit store; reset relocks everything
    lock_bit_mem #(
        .AW(LOCK_AW)
    ) u_locks (
        .clk     (hclk),
        .rst_n   (hresetn),
        .set_all (do_lock | do_rst),
        .clr_all (do_unlock),
        .rd_idx  (qidx_r),
        .rd_data (lock_bit)
    );

    // range protection from block-protect, top/bottom and complement
    wire [3:0]       bp    = cfg_r[`CFG_BP_LSB +: 4];
    wire [LOCK_AW:0] full  = (LOCK_AW + 1)'(1 << LOCK_AW);
    wire [LOCK_AW:0] span  = (bp == 4'h0) ? '0 :
                             (32'(bp) > LOCK_AW) ? full :
                             (LOCK_AW + 1)'(1 << (bp - 4'h1));
    wire [LOCK_AW:0] pos   = cfg_r[`CFG_TB] ? {1'b0, qidx_r} : {1'b0, ~qidx_r};
    wire             in_rg = (pos < span) ^ cfg_r[`CFG_CMP];
    wire             prot  = cfg_r[`CFG_PSS] ? lock_bit : in_rg;

    // bus address phase and register decode
    wire accept   = hsel & htrans[1] & hready;
    wire wr_cfg   = wr_pend_r & (addr_r == `REG_CFG);
    wire wr_vol   = wr_pend_r & (addr_r == `REG_VOL);
    wire wr_query = wr_pend_r & (addr_r == `REG_QUERY);
    wire [31:0] sts_word = {16'h0000, last_op_r, 6'h00, ~dev_ready, rst_en_r};
    wire [31:0] qres_word = {30'h0000_0000, prot, lock_bit};
    wire [31:0] rd_mux =
        (addr_r == `REG_CFG)    ? {25'h000_0000, cfg_r} :
        (addr_r == `REG_VOL)    ? {5'h00, vol_r} :
        (addr_r == `REG_STATUS) ? sts_word :
        (addr_r == `REG_QUERY)  ? {{(32 - LOCK_AW){1'b0}}, qidx_r} :
        (addr_r == `REG_QRES)   ? qres_word : 32'h0000_0000;

    // bus handshake: writes no wait, reads one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end else begin
            hresp     <= 1'b0;
            wr_pend_r <= accept & hwrite;
            if (accept) begin
                addr_r <= {haddr[7:2], 2'b00};
            end
            if (rd_pend_r) begin
                hrdata    <= rd_mux;
                hreadyout <= 1'b1;
                rd_pend_r <= 1'b0;
            end else if (accept && !hwrite) begin
                hreadyout <= 1'b0;
                rd_pend_r <= 1'b1;
            end
        end
    end

    // writable registers; a software reset wins over a bus write to the volatile register only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_r  <= `CFG_RESET;
            vol_r  <= `VOL_RESET;
            qidx_r <= '0;
        end else begin
            if (wr_cfg) begin
                cfg_r <= hwdata[`CFG_W-1:0];
            end
            if (do_rst) begin
                vol_r <= `VOL_RESET;
            end else if (wr_vol) begin
                vol_r <= hwdata[`VOL_W-1:0];
            end
            if (wr_query) begin
                qidx_r <= hwdata[LOCK_AW-1:0];
            end
        end
    end
endmodule

// ==== core/flash_lock_consts.svh ====
// constants for the global lock and software reset command block
`ifndef FLASH_LOCK_CONSTS_SVH
`define FLASH_LOCK_CONSTS_SVH
// instruction codes
`define OP_GLOBAL_LOCK    8'h7E
`define OP_GLOBAL_UNLOCK  8'h98
`define OP_RESET_ENABLE   8'h66
`define OP_RESET_DEVICE   8'h99
`define OP_BITS           4'h8
`define OP_BITS_SAT       4'h9
// timing
`define CLK_PERIOD_NS     5
`define RST_TIME_NS       30000
// register byte offsets
`define REG_CFG           8'h00
`define REG_VOL           8'h04
`define REG_STATUS        8'h08
`define REG_QUERY         8'h0C
`define REG_QRES          8'h10
// cfg fields
`define CFG_PSS           0
`define CFG_BP_LSB        1
`define CFG_TB            5
`define CFG_CMP           6
`define CFG_W             7
`define CFG_RESET         7'h00
// volatile settings fields
`define VOL_WEL           0
`define VOL_SUS           1
`define VOL_PRM_LSB       8
`define VOL_MODE_LSB      16
`define VOL_WRAP_LSB      24
`define VOL_W             27
`define VOL_RESET         27'h000_0000
// status and query result fields
`define STS_RSTEN         0
`define STS_BUSY          1
`define STS_OP_LSB        8
`define QRES_LOCK         0
`define QRES_PROT         1
`endif

// ==== core/flash_lock_pkg.sv ====
// types shared by the lock and reset command block
package flash_lock_pkg;
    typedef logic [31:0] word_t;
    typedef logic [7:0]  opcode_t;
    typedef enum logic [1:0] {
        DEV_READY     = 2'b01,
        DEV_RESETTING = 2'b10
    } dev_state_t;
endpackage

// ==== core/lock_bit_mem.sv ====
// volatile lock bit store with global set and clear and a registered read port
`timescale 1ns/1ps
module lock_bit_mem #(
    parameter int AW = 6
) (
    input  wire logic          clk,      // system clock
    input  wire logic          rst_n,    // async reset, active low
    input  wire logic          set_all,  // set every lock bit
    input  wire logic          clr_all,  // clear every lock bit
    input  wire logic [AW-1:0] rd_idx,   // entry to read
    output logic               rd_data   // registered lock bit
);
    localparam int N = 1 << AW;
    logic [N-1:0] bits_r;

    // one flop per entry, comes up locked
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    bits_r[i] <= 1'b1;
                end else if (set_all) begin
                    bits_r[i] <= 1'b1;
                end else if (clr_all) begin
                    bits_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // registered read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 1'b1;
        end else begin
            rd_data <= bits_r[rd_idx];
        end
    end
endmodule

// ==== testbench/spi_host_model.sv ====
// serial host model that issues lone opcode frames
`timescale 1ns/1ps
module spi_host_model #(
    parameter int PUW_NS = 5000000  // power_up_write_delay in ns
) (
    output logic spi_cs_n,       // chip select, active low
    output logic spi_clk,        // serial clock, still between frames
    output logic serial_data_in  // serial data
);
    import flash_lock_pkg::*;
    initial begin
        spi_cs_n = 1'b1;
        spi_clk = 1'b0;
        serial_data_in = 1'b0;
    end
    // one frame: eight bits msb first, data turned over once released
    task automatic send(input opcode_t op);
        int i;
        while ($time < PUW_NS) #5;
        #0.5; // keep pin changes off the sampling edge
        spi_cs_n = 1'b0;
        for (i = 0; i < 8; i++) begin
            serial_data_in = op[7-i];
            #32 spi_clk = 1'b1;
            #32 spi_clk = 1'b0;
        end
        #32 spi_cs_n = 1'b1;
        serial_data_in = ~serial_data_in;
        #100;
    endtask
endmodule

// ==== testbench/flash_lock_checker.sv ====
// bus timing and protection query checker for the command block
`timescale 1ns/1ps
`include "flash_lock_consts.svh"
module flash_lock_checker (
    input wire logic                  hclk,      // clock
    input wire logic                  hresetn,   // reset, active low
    input wire logic                  hsel,      // select
    input wire logic [31:0]           haddr,     // address
    input wire logic [1:0]            htrans,    // transfer type
    input wire logic                  hwrite,    // write
    input wire flash_lock_pkg::word_t hwdata,    // write data
    input wire logic                  hreadyout, // slave ready
    input wire flash_lock_pkg::word_t hrdata,    // read data
    input wire logic                  hresp      // response
);
    import flash_lock_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       rd_q;
    logic       wr_q;
    logic [7:0] a_q;
    logic [6:0] cfg_q;
    // request decode and read completion
    wire logic take_rd = hsel && htrans[1] && !hwrite && hreadyout;
    wire logic take_wr = hsel && htrans[1] && hwrite && hreadyout;
    wire logic done    = rd_q && hreadyout;
    // address phase capture, held through the wait cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            a_q  <= 8'h00;
        end else if (hreadyout) begin
            rd_q <= take_rd;
            wr_q <= take_wr;
            a_q  <= haddr[7:0];
        end
    end
    // last value written to the config register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cfg_q <= 7'h00;
        else if (wr_q && a_q == `REG_CFG) cfg_q <= hwdata[6:0];
    end
    a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
    a_read_wait: assert property (take_rd |=> !hreadyout ##1 hreadyout)
        else $error("read wait not one cycle");
    a_write_nowait: assert property (take_wr |=> hreadyout) else $error("write stalled");
    a_idle_ready: assert property (hreadyout && !take_rd |=> hreadyout)
        else $error("ready dropped without read");
    a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
        else $error("read data moved outside a read");
    a_unmapped_zero: assert property (done && a_q[7:2] >= 6'h05 |-> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_busy_no_rsten: assert property (
        done && a_q == `REG_STATUS && hrdata[`STS_BUSY] |-> !hrdata[`STS_RSTEN])
        else $error("reset enable kept after reset");
    a_scheme_lock: assert property (
        done && a_q == `REG_QRES && cfg_q[0] |-> hrdata[1] == hrdata[0])
        else $error("protection differs from lock bit");
    a_range_none: assert property (
        done && a_q == `REG_QRES && cfg_q == 7'h00 |-> !hrdata[1])
        else $error("protected with empty range");
    c_busy: cover property (done && a_q == `REG_STATUS && hrdata[`STS_BUSY]);
    c_scheme: cover property (done && a_q == `REG_QRES && cfg_q[0]);
    c_unmapped: cover property (done && a_q[7:2] >= 6'h05);
endmodule
bind flash_lock_and_reset_commands flash_lock_checker i_flash_lock_checker (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hwdata, .hreadyout, .hrdata, .hresp);

// ==== testbench/tb.sv ====
// self-checking bench for the lock and reset command block
`timescale 1ns/1ps
`include "flash_lock_consts.svh"
`define CHK(nm, got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module tb;
    import flash_lock_pkg::*;
    localparam int RST_N = 400;  // shortened reset busy time
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        rd_p = 1'b0;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    word_t       hwdata, hrdata, v;
    wire logic   spi_cs_n, spi_clk, serial_data_in;
    logic [63:0] q[$];
    logic [63:0] e;
    int          errors, n_checks, cyc;
    int unsigned seed = 22283;
    flash_lock_and_reset_commands #(.RST_CYCLES(RST_N)) i_flash_lock_and_reset_commands (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .spi_cs_n, .spi_clk, .serial_data_in);
    spi_host_model #(.PUW_NS(2000)) i_spi_host_model (.spi_cs_n, .spi_clk, .serial_data_in);
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    function automatic word_t rand32();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // single transfer: hold address until ready, then data until ready
    task automatic bus(input logic wr, input logic [7:0] a, input word_t d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h00_0000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input word_t d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input word_t m, input word_t x);
        q.push_back({m, x});
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task automatic qres(input word_t x);
        wr(`REG_QUERY, rand32() & 32'h0000_003F);
        repeat (3) @(posedge hclk);
        rd(`REG_QRES, 32'h0000_0003, x);
    endtask
    task automatic op(input opcode_t c);
        i_spi_host_model.send(c);
        repeat (8) @(posedge hclk);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // watcher: oldest note against each completed read, plus timeout
    always @(posedge hclk) begin
        cyc++;
        if (cyc > 20000) begin
            errors++;
            wrap_up();
        end else begin
            if (rd_p && hreadyout === 1'b1) begin
                e = q.pop_front();
                `CHK("hrdata", hrdata & e[63:32], e[31:0])
            end
            if (hreadyout === 1'b1) rd_p = hsel && htrans[1] && !hwrite;
        end
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values and an unmapped place
        rd(`REG_CFG, 32'h0000_007F, 32'h0000_0000);
        rd(`REG_VOL, 32'h07FF_FF03, 32'h0000_0000);
        rd(`REG_STATUS, 32'h0000_0003, 32'h0000_0000);
        qres(32'h0000_0001);
        wr(8'h40, rand32());
        rd(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
        // scheme select on, unlock the whole array
        wr(`REG_CFG, 32'h0000_0001);
        op(`OP_GLOBAL_UNLOCK);
        qres(32'h0000_0000);
        // scheme select off: whole range protected, then complemented away; scheme select on, lock the whole array
        wr(`REG_CFG, 32'h0000_000E);
        qres(32'h0000_0002);
        wr(`REG_CFG, 32'h0000_004E);
        qres(32'h0000_0000);
        wr(`REG_CFG, 32'h0000_0001);
        op(`OP_GLOBAL_LOCK);
        qres(32'h0000_0003);
        wr(`REG_CFG, 32'h0000_0000);
        // enable reset broken by another command
        v = rand32() & 32'h07FF_FF03;
        wr(`REG_VOL, v);
        op(`OP_RESET_ENABLE);
        rd(`REG_STATUS, 32'h0000_FF03, 32'h0000_6601);
        op(`OP_GLOBAL_UNLOCK);
        rd(`REG_STATUS, 32'h0000_0003, 32'h0000_0000);
        op(`OP_RESET_DEVICE);
        rd(`REG_STATUS, 32'h0000_0003, 32'h0000_0000);
        rd(`REG_VOL, 32'h07FF_FF03, v);
        // full sequence, a command while busy is ignored
        op(`OP_RESET_ENABLE);
        op(`OP_RESET_DEVICE);
        rd(`REG_STATUS, 32'h0000_0003, 32'h0000_0002);
        op(`OP_GLOBAL_UNLOCK);
        repeat (RST_N) @(posedge hclk);
        rd(`REG_STATUS, 32'h0000_0003, 32'h0000_0000);
        rd(`REG_VOL, 32'h07FF_FF03, 32'h0000_0000);
        qres(32'h0000_0001);
        // lone reset after completion does nothing
        op(`OP_RESET_DEVICE);
        rd(`REG_STATUS, 32'h0000_0003, 32'h0000_0000);
        wrap_up();
    end
endmodule
